// *** src/pvc_regs.sv ***
// Output-control command register set with slew-limited reference stepping.
// Assumes a front end on clk_sys delivering one pvc_cmd_s per cmd_valid pulse.
//
// Function
// RQ1 - Reset command restores all registers and faults.
// RQ2 - Reset command requests address resistor re-measure.
// RQ3 - Reset command write-only, takes 0-2 bytes.
// RQ4 - Rail address 7 bits, bit7 disables, default off.
// RQ5 - Rail read mismatch flags communication fault.
// RQ6 - Rail address takes one or two bytes.
// RQ7 - Output off keeps bus, slows telemetry 1Hz.
// RQ8 - On bit clears on run low, reset.
// RQ9 - Margin bits select margin setpoint, slewed.
// RQ10 - On toggling leaves margin setpoints untouched.
// RQ11 - Only 00, 80, 98, A8 control accepted.
// RQ12 - Control takes two bytes, second ignored.
// RQ13 - Format code reads 3F; writes fault.
// RQ14 - Config bits 1:0 pick slew multiplier.
// RQ15 - Config bit 2 picks temperature source.
// RQ16 - Config clears on reset and run cycle.
// RQ17 - Setpoint is 9-bit code, 0.1953 percent steps.
// RQ18 - Host never writes setpoint above full scale.
// RQ19 - Active setpoint change is slew limited.
// RQ20 - Setpoint resets to zero on events.
// RQ21 - Low margin setpoint same format, same reset.
// RQ22 - Reference counts toward target per step.
// RQ23 - Both margin bits set: write ignored.
// RQ24 - Word commands arrive low byte first.
`timescale 1ns/1ps

module pvc_regs #(
   parameter int STEP_CYC = pvc_pkg::STEP_CYCLES,
   parameter int FAST_MS  = pvc_pkg::TELEM_FAST_MS,
   parameter int SLOW_MS  = pvc_pkg::TELEM_SLOW_MS
) (
   // Clock and reset.
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   // Command stream from the bus front end.
   input  wire logic             cmd_valid,
   input  wire pvc_pkg::pvc_cmd_s cmd,
   input  wire logic [7:0]       rail_read_seen,
   // Run pin, synchronised inside the block.
   input  wire logic             run_pin,
   // Read data back to the front end.
   output logic [15:0]           rd_data,
   // Block state toward the analog side.
   output logic                  output_on,
   output logic [8:0]            reference_code,
   output logic                  ref_settled,
   output logic [1:0]            slew_mult,
   output logic                  temp_src_external,
   output logic                  telem_slow,
   output logic                  rail_enable,
   output logic [6:0]            rail_addr,
   output logic                  address_select_resistor_measure,
   output logic                  communication_fault,
   output logic                  faults_clear
);

   // Each command is one pvc_cmd_s under a strobe.
   // Its effects show one cycle after the strobe.
   // One command may come every cycle.
   // A run fall or the reset command clears
   // control, config and setpoints.
   // The reset command also clears the rail
   // address, the fault and the reference.
   // The reference walks one code per step.
   // A step is STEP_CYC cycles at nominal rate,
   // eight times that when slow, half when fast.
   // Margin high beats low; both together
   // are refused at the decode.
   // Words carry the low byte first.
   // Refused writes other than to the format code are silent.
   // Nothing here waits on the analog side.
   // The run pin is synchronised before use.

   ////////////////////////////////////////////////////////////////////////////
   // Run pin synchroniser and edge detection.

   logic run_meta_reg;   // First stage; only run_sync_reg reads it.
   logic run_sync_reg;   // Second stage.
   logic run_last_reg;   // Previous synchronised level.

   // Two flops bring the pin into the clock domain.
   // Reset low, so a pin idling high gives no false fall.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         run_meta_reg <= 1'b0;
         run_sync_reg <= 1'b0;
         run_last_reg <= 1'b0;
      end else begin
         run_meta_reg <= run_pin;
         run_sync_reg <= run_meta_reg;
         run_last_reg <= run_sync_reg;
      end
   end

   // A falling run level is a master shutdown.
   // A rising level needs no action here.
   wire run_fall = run_last_reg & ~run_sync_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode.

   // Register state, declared here as the decode reads it.
   logic [7:0] ctrl_reg;   // Control byte.
   logic [7:0] rail_reg;   // Rail address and disable bit.
   logic [7:0] cfg_reg;    // Configuration byte.
   logic [8:0] nom_reg;    // Nominal setpoint.
   logic [8:0] low_reg;    // Low margin setpoint.
   logic [8:0] high_reg;   // High margin setpoint.
   logic       fault_reg;  // Sticky communication fault.
   logic       address_select_resistor_reg;   // Re-measure request pulse.
   logic       clr_reg;    // Fault clear pulse.

   // Strobe qualifiers.
   wire is_wr = cmd_valid & cmd.write;
   wire is_rd = cmd_valid & cmd.read;

   // Reset command: any byte count up to two, bytes discarded. [RQ3]
   wire wr_reset  = is_wr & (cmd.code == pvc_pkg::CMD_DEVICE_RESET_TRIGGER);
   // Rail address with one or two bytes, second ignored. [RQ6]
   wire wr_rail   = is_wr & (cmd.code == pvc_pkg::CMD_SHARED_RAIL_ADDRESS)
                    & (cmd.nbytes != 2'h0);
   // Control byte; the second byte of a two-byte write is ignored. [RQ12]
   wire ctrl_hit  = is_wr & (cmd.code == pvc_pkg::CMD_OUTPUT_ON_MARGIN)
                    & (cmd.nbytes != 2'h0);
   // Only the four listed values are legal. [RQ11]
   wire ctrl_ok   = (cmd.lo == pvc_pkg::CTRL_OFF) | (cmd.lo == pvc_pkg::CTRL_ON)
                    | (cmd.lo == pvc_pkg::CTRL_MARGIN_LO)
                    | (cmd.lo == pvc_pkg::CTRL_MARGIN_HI);
   // Both margin bits at once is illegal and dropped. [RQ23]
   wire both_mrg  = cmd.lo[pvc_pkg::CTRL_MHI_BIT] & cmd.lo[pvc_pkg::CTRL_MLO_BIT];
   wire wr_ctrl   = ctrl_hit & ctrl_ok & ~both_mrg;
   // Config byte; slew code 11b is illegal. [RQ14]
   wire wr_cfg    = is_wr & (cmd.code == pvc_pkg::CMD_SLEW_TEMP_CONFIG)
                    & (cmd.nbytes != 2'h0) & (cmd.lo[1:0] != 2'h3);
   // Words are taken low byte first. [RQ24]
   wire wr_nom    = is_wr & (cmd.code == pvc_pkg::CMD_REFERENCE_SETPOINT)
                    & (cmd.nbytes == 2'h2);
   // Margin setpoints share the word format. [RQ21]
   wire wr_low    = is_wr & (cmd.code == pvc_pkg::CMD_LOW_MARGIN_SETPOINT)
                    & (cmd.nbytes == 2'h2);
   wire wr_high   = is_wr & (cmd.code == pvc_pkg::CMD_HIGH_MARGIN_SETPOINT)
                    & (cmd.nbytes == 2'h2);
   // Writing the format code is a fault. [RQ13]
   wire wr_fmt    = is_wr & (cmd.code == pvc_pkg::CMD_OUTPUT_FORMAT_CODE);
   // A rail read that came back different is contention. [RQ5]
   wire rail_clash = is_rd & (cmd.code == pvc_pkg::CMD_SHARED_RAIL_ADDRESS)
                     & (rail_read_seen != rail_reg);
   // Either event raises the sticky fault.
   wire fault_evt  = wr_fmt | rail_clash;

   // Run fall or reset command both restore the run-cycle registers.
   wire soft_clr = wr_reset | run_fall;

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // Control register: on bit cleared by reset command or run fall. [RQ8]
   // A refused value leaves the byte as it was.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= pvc_pkg::RST_CTRL;
      end else if (soft_clr) begin
         ctrl_reg <= pvc_pkg::RST_CTRL;  // [RQ1] [RQ8]
      end else if (wr_ctrl) begin
         ctrl_reg <= cmd.lo;             // [RQ11]
      end
   end

   // Rail address register, disabled by default. [RQ4]
   // A run fall leaves it; only the reset command clears it.
   // Bit 7 high keeps the shared address silent.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rail_reg <= pvc_pkg::RST_RAIL;
      end else if (wr_reset) begin
         rail_reg <= pvc_pkg::RST_RAIL;  // [RQ1]
      end else if (wr_rail) begin
         rail_reg <= cmd.lo;             // [RQ4] [RQ6]
      end
   end

   // Configuration register; illegal slew code 11b is refused. [RQ14] [RQ16]
   // Bits 1:0 slew multiplier, bit 2 temperature source.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg <= pvc_pkg::RST_CONFIG;
      end else if (soft_clr) begin
         cfg_reg <= pvc_pkg::RST_CONFIG; // [RQ16]
      end else if (wr_cfg) begin
         cfg_reg <= cmd.lo;
      end
   end

   // Setpoints: 9-bit codes from low byte plus bit 0 of high byte. [RQ17] [RQ21]
   // Output on/off does not touch them. [RQ10]
   // Bits 15:9 of a word are dropped.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         nom_reg  <= pvc_pkg::RST_SETPOINT;
         low_reg  <= pvc_pkg::RST_SETPOINT;
         high_reg <= pvc_pkg::RST_SETPOINT;
      end else if (soft_clr) begin
         nom_reg  <= pvc_pkg::RST_SETPOINT; // [RQ20]
         low_reg  <= pvc_pkg::RST_SETPOINT; // [RQ21]
         high_reg <= pvc_pkg::RST_SETPOINT;
      end else begin
         // At most one setpoint per command.
         if (wr_nom) begin
            nom_reg <= {cmd.hi[0], cmd.lo};  // [RQ24]
         end
         if (wr_low) begin
            low_reg <= {cmd.hi[0], cmd.lo};
         end
         if (wr_high) begin
            high_reg <= {cmd.hi[0], cmd.lo};
         end
      end
   end

   // Communication fault: set beats the reset-command clear. [RQ5] [RQ13]
   // Only a reset clears it.
   // It stays set across run falls.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fault_reg <= 1'b0;
      end else if (fault_evt) begin
         fault_reg <= 1'b1;
      end else if (wr_reset) begin
         fault_reg <= 1'b0;              // [RQ1]
      end
   end

   // Reset command pulses address re-measure and fault clear. [RQ2] [RQ1]
   // Power-on reset leaves one re-measure request too.
   // A lone reset command gives each pulse for one cycle; the power-on request holds through reset and one cycle after.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         address_select_resistor_reg <= 1'b1;
         clr_reg  <= 1'b0;
      end else begin
         address_select_resistor_reg <= wr_reset;           // [RQ2]
         clr_reg  <= wr_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference target selection and slew stepping.

   wire on_now = ctrl_reg[pvc_pkg::CTRL_ON_BIT];
   // Margin bit picks its setpoint; off targets zero. [RQ9]
   // The setpoints are kept while off. [RQ10]
   // High is tested first; both set is refused.
   wire [8:0] target = !on_now ? pvc_pkg::RST_SETPOINT :
                       ctrl_reg[pvc_pkg::CTRL_MHI_BIT] ? high_reg :
                       ctrl_reg[pvc_pkg::CTRL_MLO_BIT] ? low_reg : nom_reg;

   // Step period scaled by the multiplier. [RQ14] [RQ19]
   // Slow steps are eight times longer, fast ones half.
   wire [19:0] step_len = (cfg_reg[1:0] == pvc_pkg::SLEW_SLOW) ? 20'(STEP_CYC * 8) :
                          (cfg_reg[1:0] == pvc_pkg::SLEW_FAST) ? 20'(STEP_CYC / 2) :
                          20'(STEP_CYC);

   // Present reference and cycles spent in this step.
   logic [8:0]  ref_reg;
   logic [19:0] step_cnt_reg;

   // Count one code per step toward the target. [RQ22] [RQ19]
   // The reset command snaps it to zero without slewing.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ref_reg      <= pvc_pkg::RST_SETPOINT;
         step_cnt_reg <= 20'h00000;
      end else if (wr_reset) begin
         ref_reg      <= pvc_pkg::RST_SETPOINT;
         step_cnt_reg <= 20'h00000;
      end else if (ref_reg == target) begin
         // Settled: keep the step counter clear.
         step_cnt_reg <= 20'h00000;
      end else if (step_cnt_reg + 20'h00001 >= step_len) begin
         // Step period done: move one code.
         step_cnt_reg <= 20'h00000;
         ref_reg      <= (ref_reg < target) ? ref_reg + 9'h001 : ref_reg - 9'h001;
      end else begin
         step_cnt_reg <= step_cnt_reg + 20'h00001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux, registered.

   logic [15:0] rd_next;

   // Selects read data by command code.
   // Write-only and unknown codes read as zero.
   // Only a read strobe loads the result.
   always_comb begin
      rd_next = 16'h0000;
      unique case (cmd.code)
         pvc_pkg::CMD_SHARED_RAIL_ADDRESS:  rd_next = {8'h00, rail_reg};
         pvc_pkg::CMD_OUTPUT_ON_MARGIN:     rd_next = {8'h00, ctrl_reg};
         pvc_pkg::CMD_OUTPUT_FORMAT_CODE:   rd_next = {8'h00, pvc_pkg::OUTPUT_FORMAT_VAL};
         pvc_pkg::CMD_SLEW_TEMP_CONFIG:     rd_next = {8'h00, cfg_reg};
         pvc_pkg::CMD_REFERENCE_SETPOINT:   rd_next = {7'h00, nom_reg};
         pvc_pkg::CMD_LOW_MARGIN_SETPOINT:  rd_next = {7'h00, low_reg};
         pvc_pkg::CMD_HIGH_MARGIN_SETPOINT: rd_next = {7'h00, high_reg};
         default:                           rd_next = 16'h0000;
      endcase
   end

   logic [15:0] rd_reg;

   // Captures read data on a read request; format code always 3F. [RQ13]
   // Between reads the last data stands.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rd_reg <= 16'h0000;
      end else if (is_rd) begin
         rd_reg <= rd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Read data.
   assign rd_data             = rd_reg;
   // State toward the analog side.
   assign output_on           = on_now;
   assign reference_code      = ref_reg;
   assign ref_settled         = (ref_reg == target);
   assign slew_mult           = cfg_reg[1:0];                       // [RQ14]
   assign temp_src_external   = cfg_reg[pvc_pkg::CFG_TEMP_SRC_BIT]; // [RQ15]
   assign telem_slow          = ~on_now;                            // [RQ7]
   assign rail_enable         = ~rail_reg[pvc_pkg::RAIL_DISABLE_BIT]; // [RQ4]
   assign rail_addr           = rail_reg[6:0];
   // Pulses and flags.
   assign address_select_resistor_measure        = address_select_resistor_reg;
   assign communication_fault = fault_reg;
   assign faults_clear        = clr_reg;

endmodule

// *** src/pvc_pkg.sv ***
// Package for the output-control command register set: command codes, field
// positions, reset values and slew timing constants.
// Assumes a PMBus front end that hands over decoded command bytes.
package pvc_pkg;

   // Command codes seen on the byte stream.
   localparam logic [7:0] CMD_DEVICE_RESET_TRIGGER = 8'hFD;
   localparam logic [7:0] CMD_SHARED_RAIL_ADDRESS  = 8'hFA;
   localparam logic [7:0] CMD_OUTPUT_ON_MARGIN     = 8'h01;
   localparam logic [7:0] CMD_OUTPUT_FORMAT_CODE   = 8'h20;
   localparam logic [7:0] CMD_SLEW_TEMP_CONFIG     = 8'hD0;
   localparam logic [7:0] CMD_REFERENCE_SETPOINT   = 8'hD5;
   localparam logic [7:0] CMD_LOW_MARGIN_SETPOINT  = 8'hD6;
   localparam logic [7:0] CMD_HIGH_MARGIN_SETPOINT = 8'hD7;

   // Accepted control values.
   localparam logic [7:0] CTRL_OFF       = 8'h00;
   localparam logic [7:0] CTRL_ON        = 8'h80;
   localparam logic [7:0] CTRL_MARGIN_LO = 8'h98;
   localparam logic [7:0] CTRL_MARGIN_HI = 8'hA8;

   // Field positions.
   localparam int CTRL_ON_BIT      = 7;
   localparam int CTRL_MHI_BIT     = 5;
   localparam int CTRL_MLO_BIT     = 4;
   localparam int RAIL_DISABLE_BIT = 7;
   localparam int CFG_TEMP_SRC_BIT = 2;

   // Reset values and the fixed format code value.
   localparam logic [7:0] RST_CTRL          = 8'h00;
   localparam logic [7:0] RST_RAIL          = 8'h80;
   localparam logic [7:0] RST_CONFIG        = 8'h00;
   localparam logic [8:0] RST_SETPOINT      = 9'h000;
   localparam logic [7:0] OUTPUT_FORMAT_VAL = 8'h3F;

   // Slew multiplier codes.
   localparam logic [1:0] SLEW_NOMINAL = 2'h0;
   localparam logic [1:0] SLEW_SLOW    = 2'h1;
   localparam logic [1:0] SLEW_FAST    = 2'h2;

   // Reference step time at nominal rate, in ns, and its cycle count at 50 MHz.
   localparam int CLK_PERIOD_NS  = 20;
   localparam int STEP_TIME_NS   = 80000;
   localparam int STEP_CYCLES    = STEP_TIME_NS / CLK_PERIOD_NS;

   // Telemetry refresh periods in ms.
   localparam int TELEM_FAST_MS  = 40;
   localparam int TELEM_SLOW_MS  = 1000;

   // One decoded command from the front end.
   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] code;
      logic [1:0] nbytes;
      logic [7:0] lo;
      logic [7:0] hi;
   } pvc_cmd_s;

endpackage

// *** test/pvc_regs_props.sv ***
// Checker for the output-control register set.
// Sees only the ports of pvc_regs and is bound to every instance of it.
`timescale 1ns/1ps

module pvc_regs_props #(
   parameter int STEP_CYC = 4,
   parameter int FAST_MS  = 40,
   parameter int SLOW_MS  = 1000
) (
   // Clock and reset.
   input wire logic              clk_sys,
   input wire logic              reset_n,
   // Command stream.
   input wire logic              cmd_valid,
   input wire pvc_pkg::pvc_cmd_s cmd,
   input wire logic [7:0]        rail_read_seen,
   input wire logic              run_pin,
   // Block outputs.
   input wire logic [15:0]       rd_data,
   input wire logic              output_on,
   input wire logic [8:0]        reference_code,
   input wire logic              ref_settled,
   input wire logic [1:0]        slew_mult,
   input wire logic              temp_src_external,
   input wire logic              telem_slow,
   input wire logic              rail_enable,
   input wire logic [6:0]        rail_addr,
   input wire logic              address_select_resistor_measure,
   input wire logic              communication_fault,
   input wire logic              faults_clear
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // Qualified write and read strobes and the legal control values.
   wire wr = cmd_valid && cmd.write;
   wire rd = cmd_valid && cmd.read;
   wire ctl_ok = cmd.lo inside {8'h00, 8'h80, 8'h98, 8'hA8};

   ////////////////////////////////////////////////////////////////////////////
   a_fmt_fault: assert property (wr && cmd.code == 8'h20 |=> communication_fault)
      else $error("format code write left the fault clear");
   a_fmt_read: assert property (rd && cmd.code == 8'h20 |=> rd_data == 16'h003F)
      else $error("format code read wrong");
   a_reset_pulse: assert property (wr && cmd.code == 8'hFD |=>
      faults_clear && address_select_resistor_measure)
      else $error("reset command gave no clear and measure pulses");
   a_reset_off: assert property (wr && cmd.code == 8'hFD |=>
      !output_on && slew_mult == 2'h0 && !temp_src_external)
      else $error("reset command left output or config set");
   a_ctrl_bad: assert property (wr && cmd.code == 8'h01 && !ctl_ok |=>
      $stable(output_on) && $stable(telem_slow))
      else $error("illegal control value took effect");
   a_ctrl_on: assert property (wr && cmd.code == 8'h01 && ctl_ok &&
      cmd.nbytes != 2'h0 |=> output_on == $past(cmd.lo[7]))
      else $error("output on bit not taken from control byte");
   a_rail_write: assert property (wr && cmd.code == 8'hFA && cmd.nbytes != 2'h0 |=>
      rail_addr == $past(cmd.lo[6:0]) && rail_enable == !$past(cmd.lo[7]))
      else $error("rail address write wrong");
   a_rail_clash: assert property (rd && cmd.code == 8'hFA &&
      rail_read_seen != {!rail_enable, rail_addr} |=> communication_fault)
      else $error("rail read mismatch not flagged");
   a_telem_slow: assert property ($fell(output_on) |-> ##[0:1] telem_slow)
      else $error("telemetry not slowed with output off");
   a_ref_step: assert property ($changed(reference_code) && !faults_clear &&
      !$past(faults_clear) |-> reference_code == $past(reference_code) + 9'h001 ||
      reference_code == $past(reference_code) - 9'h001)
      else $error("reference moved by more than one code");

   // Main scenarios reached.
   c_margin: cover property (wr && cmd.code == 8'h01 && cmd.lo == 8'h98);
   c_clash: cover property ($rose(communication_fault));
   c_settle: cover property ($rose(ref_settled));
endmodule

bind pvc_regs pvc_regs_props #(
   .STEP_CYC(STEP_CYC), .FAST_MS(FAST_MS), .SLOW_MS(SLOW_MS)
) i_props (
   .clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
   .rail_read_seen(rail_read_seen), .run_pin(run_pin), .rd_data(rd_data),
   .output_on(output_on), .reference_code(reference_code), .ref_settled(ref_settled),
   .slew_mult(slew_mult), .temp_src_external(temp_src_external),
   .telem_slow(telem_slow), .rail_enable(rail_enable), .rail_addr(rail_addr),
   .address_select_resistor_measure(address_select_resistor_measure), .communication_fault(communication_fault),
   .faults_clear(faults_clear)
);

// *** test/pvc_host_model.sv ***
// Host-side model issuing decoded bus commands to the register set.
// Assumes clk_sys; it changes its outputs only on the falling edge.
`timescale 1ns/1ps

module pvc_host_model (
   // Clock.
   input  wire logic        clk_sys,
   // Command stream toward the register set.
   output pvc_pkg::pvc_cmd_s cmd,
   output logic             cmd_valid,
   output logic [7:0]       rail_read_seen
);
   // Idle at time zero.
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
      rail_read_seen = 8'h00;
   end

   // One transfer held across one rising edge, then scrambled so stale data is not reused.
   task automatic xfer(input logic w, input logic [7:0] code, input logic [1:0] nb,
                       input logic [15:0] d, input logic [7:0] seen);
      logic [7:0] hi;
      hi = d[15:8];
      if (code inside {8'hD5, 8'hD6, 8'hD7}) begin
         hi = {7'h00, d[8]};
      end
      @(negedge clk_sys);
      cmd = '{write: w, read: !w, code: code, nbytes: nb, lo: d[7:0], hi: hi};
      rail_read_seen = seen;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      cmd = ~cmd;
      rail_read_seen = ~rail_read_seen;
   endtask
endmodule

// *** test/pvc_regs_tb_top.sv ***
// Self-checking bench for the output-control register set.
// Drives commands through the host model; step time shortened to SC cycles.
`timescale 1ns/1ps

module pvc_regs_tb_top;
   localparam int SC = 4;  // Shortened reference step time in cycles.
   logic clk_sys, reset_n, run_pin, cmd_valid;
   pvc_pkg::pvc_cmd_s cmd;
   logic [7:0] rail_read_seen;
   logic [15:0] rd_data;
   logic output_on, ref_settled, temp_src_external, telem_slow, rail_enable;
   logic address_select_resistor_measure, communication_fault, faults_clear;
   logic [8:0] reference_code;
   logic [1:0] slew_mult;
   logic [6:0] rail_addr;
   int n_fail, n_compared;
   // Power-on contents; the rail register is last as the run pin keeps it.
   logic [7:0] dcode [6] = '{8'h01, 8'hD0, 8'hD5, 8'hD6, 8'h20, 8'hFA};
   logic [15:0] dval [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h003F, 16'h0080};
   logic [7:0] ctl [4] = '{8'h80, 8'h98, 8'hA8, 8'h00};

   pvc_regs #(.STEP_CYC(SC)) i_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .rail_read_seen(rail_read_seen), .run_pin(run_pin), .rd_data(rd_data),
      .output_on(output_on), .reference_code(reference_code), .ref_settled(ref_settled),
      .slew_mult(slew_mult), .temp_src_external(temp_src_external),
      .telem_slow(telem_slow), .rail_enable(rail_enable), .rail_addr(rail_addr),
      .address_select_resistor_measure(address_select_resistor_measure), .communication_fault(communication_fault),
      .faults_clear(faults_clear));
   pvc_host_model i_host (.clk_sys(clk_sys), .cmd(cmd), .cmd_valid(cmd_valid),
      .rail_read_seen(rail_read_seen));

   // 50 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compares one value and counts it.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [1:0] nb, input logic [15:0] d);
      i_host.xfer(1'b1, c, nb, d, 8'h00);
   endtask
   // Reads back; the bus shows what the block drove, so no clash is made.
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
      i_host.xfer(1'b0, c, 2'h1, 16'h0000, exp[7:0]);
      chk($sformatf("read %h", c), exp, rd_data);
   endtask
   task automatic defaults(input int n);
      for (int i = 0; i < n; i++) rd_chk(dcode[i], dval[i]);
   endtask
   // Waits for the reference to land and checks how long the ramp took.
   task automatic settle(input logic [8:0] code, input int lo, input int hi);
      int n;
      n = 0;
      while (reference_code !== code && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      chk("reference", {7'h00, code}, {7'h00, reference_code});
      chk("settled", 1, ref_settled);
      chk("ramp time", 1, n >= lo && n <= hi);
   endtask
   task automatic results;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the expected run.
   initial begin
      #100us;
      n_fail++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      run_pin = 1'b1;
      n_fail = 0;
      n_compared = 0;
      repeat (16) @(negedge clk_sys);
      reset_n = 1'b1;
      defaults(6);
      // Fault, config and reset command with zero, one and two bytes.
      for (int nb = 0; nb < 3; nb++) begin
         wr(8'h20, 2'h1, 16'h0055);
         chk("fault", 1, communication_fault);
         wr(8'hD0, 2'h1, 16'h0006);
         wr(8'hFD, nb[1:0], 16'hFFFF);
         chk("reset pulses", 2'h3, {address_select_resistor_measure, faults_clear});
         @(negedge clk_sys);
         chk("fault", 0, communication_fault);
         defaults(6);
      end
      // Rail address: one and two bytes, then a read clash.
      wr(8'hFA, 2'h1, 16'h0035);
      chk("rail", 16'h00B5, {rail_enable, rail_addr});
      wr(8'hFA, 2'h2, 16'h12AA);
      rd_chk(8'hFA, 16'h00AA);
      chk("fault", 0, communication_fault);
      i_host.xfer(1'b0, 8'hFA, 2'h1, 16'h0000, 8'hAB);
      chk("fault", 1, communication_fault);
      wr(8'hFD, 2'h0, 16'h0000);
      // Every control value with a discarded second byte, then illegal ones.
      foreach (ctl[i]) begin
         wr(8'h01, 2'h2, {8'hFF, ctl[i]});
         rd_chk(8'h01, {8'h00, ctl[i]});
         chk("telemetry slow", !ctl[i][7], telem_slow);
      end
      wr(8'h01, 2'h1, 16'h0080);
      wr(8'h01, 2'h1, 16'h00B8);
      wr(8'h01, 2'h1, 16'h0040);
      rd_chk(8'h01, 16'h0080);
      wr(8'h01, 2'h1, 16'h0000);
      // Config: illegal slew refused, then each field.
      wr(8'hD0, 2'h1, 16'h0007);
      rd_chk(8'hD0, 16'h0000);
      wr(8'hD0, 2'h1, 16'h0005);
      chk("config out", 16'h0005, {temp_src_external, slew_mult});
      wr(8'hD0, 2'h1, 16'h0000);
      // Ramps at nominal, fast and slow rates.
      wr(8'hD5, 2'h2, 16'h0005);
      wr(8'hD6, 2'h2, 16'h0002);
      wr(8'h01, 2'h1, 16'h0080);
      settle(9'h005, 4 * SC, 6 * SC + 4);
      wr(8'hD0, 2'h1, 16'h0002);
      wr(8'hD5, 2'h2, 16'h0009);
      settle(9'h009, 3 * SC / 2, 5 * SC / 2 + 4);
      wr(8'hD0, 2'h1, 16'h0001);
      wr(8'h01, 2'h1, 16'h0098);
      settle(9'h002, 6 * 8 * SC, 8 * 8 * SC + 4);
      // Off and on again restores the margin state.
      wr(8'h01, 2'h1, 16'h0000);
      settle(9'h000, 8 * SC, 3 * 8 * SC + 4);
      rd_chk(8'hD6, 16'h0002);
      wr(8'h01, 2'h1, 16'h0098);
      settle(9'h002, 8 * SC, 3 * 8 * SC + 4);
      // Margin high moves to the high setpoint.
      wr(8'hD7, 2'h2, 16'h0004);
      wr(8'h01, 2'h1, 16'h00A8);
      settle(9'h004, 8 * SC, 3 * 8 * SC + 4);
      wr(8'hD5, 2'h2, 16'hFFFF);
      rd_chk(8'hD5, 16'h01FF);
      // Run pin cycle clears control, config and setpoints.
      run_pin = 1'b0;
      repeat (6) @(negedge clk_sys);
      run_pin = 1'b1;
      repeat (6) @(negedge clk_sys);
      defaults(6);
      results();
   end
endmodule
